/* File: twp_load_model.sv */
// External load on the waveform pin: the level the circuit sees.
module twp_load_model (
    // Clock.
    input wire logic ref_clk,
    // Pin driver.
    input wire logic pin_out,
    input wire logic pin_oe,
    // Level seen by the load.
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    // A released pin floats, so it shows a level that flips every cycle.
    always_ff @(posedge ref_clk)
        last <= pin_oe ? pin_out : ~last;
    assign pin_level = pin_oe ? pin_out : ~last;
endmodule : twp_load_model

/* File: twp_pkg.sv */
// Shared constants and types for the 8-bit timer waveform block.
package twp_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [3:0] twp_ctrl_addr = 4'h0;
    localparam logic [3:0] twp_count_addr = 4'h4;
    localparam logic [3:0] twp_cmp_addr = 4'h8;
    localparam logic [3:0] twp_flag_addr = 4'hc;
    // Control register field positions.
    localparam int twp_force_bit = 7;
    localparam int twp_wsel_hi_bit = 6;
    localparam int twp_act_hi_bit = 5;
    localparam int twp_act_lo_bit = 4;
    localparam int twp_wsel_lo_bit = 3;
    // Flag register field positions.
    localparam int twp_match_bit = 1;
    localparam int twp_ovf_bit = 0;
    // Counter limits and reset values.
    localparam logic [7:0] twp_max = 8'hff;
    localparam logic [7:0] twp_bottom = 8'h00;
    localparam logic [7:0] twp_one = 8'h01;
    localparam logic [7:0] twp_byte_rst = 8'h00;
    // Output-action encodings.
    localparam logic [1:0] twp_act_off = 2'h0;
    localparam logic [1:0] twp_act_tog = 2'h1;
    localparam logic [1:0] twp_act_clr = 2'h2;
    localparam logic [1:0] twp_act_set = 2'h3;
    // Waveform-select encodings.
    localparam logic [1:0] twp_wsel_normal = 2'h0;
    localparam logic [1:0] twp_wsel_phase = 2'h1;
    localparam logic [1:0] twp_wsel_match_clr = 2'h2;
    localparam logic [1:0] twp_wsel_fast = 2'h3;

    typedef enum logic [1:0] {
        twp_normal,
        twp_phase,
        twp_match_clr,
        twp_fast
    } twp_mode_type;
endpackage : twp_pkg

/* File: twp_timer.sv */
// 8-bit timer with waveform generation, reached over APB.
// How it works
// - Bits 6 and 3 select normal, phase PWM, clear-on-match, fast PWM.
// - Compare value loads at once outside PWM, at TOP inside PWM.
// - Fast PWM: action 2 clears on match, sets at TOP; 3 inverts.
// - Fast PWM TOP transition happens on the MAX-to-BOTTOM wrap tick.
// - Compare BOTTOM spikes one tick; compare TOP keeps output constant.
// - Phase PWM counts up to MAX, then down to BOTTOM, repeating.
// - Phase PWM holds MAX one tick, period 510 ticks.
// - Phase PWM: action 2 clears up-match, sets down-match; 3 inverts.
// - Phase PWM compare BOTTOM gives constant low, MAX constant high.
// - Non-PWM actions: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Nonzero action routes waveform to pin; direction bit enables it.
// - Force bit outside PWM applies the action immediately.
// - Forced compare sets no flag and never clears the counter.
// - Force bit reads zero; software writes it zero in PWM modes.
// - Counter advances only on clock cycles with timer tick high.
// - Fast PWM counts BOTTOM to MAX then restarts at BOTTOM.
// - Clear-on-match clears the counter on the matching tick itself.
// - Match flag sets on true match; cleared by ack or write one.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module twp_timer
    import twp_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer tick enable and interrupt vector acknowledges.
    input wire logic timer_tick,
    input wire logic match_ack,
    input wire logic overflow_ack,
    // Port pin.
    input wire logic pin_dir,
    input wire logic port_data,
    output logic pin_out,
    output logic pin_oe,
    // Status.
    output logic wave_out,
    output logic match_flag,
    output logic overflow_flag
);
    logic [7:0] timer_mode_control;
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_active;
    logic count_up;
    logic match_block;
    logic wave_level;
    logic next_level;
    logic [7:0] next_count;
    twp_mode_type mode;
    logic [1:0] output_action;
    logic [1:0] wsel;
    logic pwm_mode;
    logic up_now;
    logic match;
    logic top_hit;
    logic force_hit;
    logic wr_en;
    logic mapped;
    logic [3:0] addr_lo;
    logic [7:0] rd_byte;

    assign wsel = {timer_mode_control[twp_wsel_hi_bit],
        timer_mode_control[twp_wsel_lo_bit]};
    assign output_action = timer_mode_control[twp_act_hi_bit:twp_act_lo_bit];
    assign pwm_mode = (mode == twp_phase) || (mode == twp_fast);
    assign addr_lo = paddr[3:0];
    assign mapped = (paddr[31:4] == 28'h0000000) && (addr_lo[1:0] == 2'h0);
    assign wr_en = psel && penable && pready && pwrite && mapped;

    always_comb
    begin
        unique case (wsel)
            twp_wsel_normal: mode = twp_normal;
            twp_wsel_phase: mode = twp_phase;
            twp_wsel_match_clr: mode = twp_match_clr;
            twp_wsel_fast: mode = twp_fast;
        endcase
    end

    // Direction at the turning points wins over the stored direction.
    assign up_now = (count_value == twp_bottom) ? 1'b1
        : (count_value == twp_max) ? 1'b0 : count_up;
    // A counter write suppresses the match on the following tick.
    assign match = timer_tick && !match_block
        && (count_value == compare_active);
    assign top_hit = timer_tick && (count_value == twp_max);
    assign force_hit = wr_en && (addr_lo == twp_ctrl_addr)
        && pwdata[twp_force_bit]
        && !(pwdata[twp_wsel_lo_bit]);

    always_comb
    begin
        next_count = count_value;
        if (timer_tick)
        begin
            unique case (mode)
                twp_normal, twp_fast:
                    next_count = count_value + twp_one;
                twp_match_clr:
                    // A count write blocks the clear as it blocks the match.
                    next_count = match
                        ? twp_bottom : count_value + twp_one;
                twp_phase:
                    next_count = up_now ? count_value + twp_one
                        : count_value - twp_one;
            endcase
        end
    end

    twp_wave_action u_action (
        .mode(mode),
        .output_action(wr_en && addr_lo == twp_ctrl_addr
            ? pwdata[twp_act_hi_bit:twp_act_lo_bit] : output_action),
        .compare_active(compare_active),
        .match(match),
        .top_hit(top_hit),
        .up_now(up_now),
        .force_hit(force_hit),
        .level(wave_level),
        .next_level(next_level)
    );

    // Control register; the force bit is a strobe and is never stored.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            timer_mode_control <= twp_byte_rst;
        else if (wr_en && addr_lo == twp_ctrl_addr)
            timer_mode_control <= {1'b0,
                pwdata[twp_wsel_hi_bit:twp_wsel_lo_bit], 3'h0};
    end

    // Counter and its direction.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            count_value <= twp_byte_rst;
            count_up <= 1'b1;
            match_block <= 1'b0;
        end
        else if (wr_en && addr_lo == twp_count_addr)
        begin
            count_value <= pwdata[7:0];
            match_block <= 1'b1;
        end
        else
        begin
            count_value <= next_count;
            count_up <= up_now;
            if (timer_tick)
                match_block <= 1'b0;
        end
    end

    // Compare value and its double buffer.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            compare_value <= twp_byte_rst;
            compare_active <= twp_byte_rst;
        end
        else
        begin
            if (wr_en && addr_lo == twp_cmp_addr)
                compare_value <= pwdata[7:0];
            // PWM modes hold the old value until TOP to avoid glitches.
            if (!pwm_mode)
                compare_active <= (wr_en && addr_lo == twp_cmp_addr)
                    ? pwdata[7:0] : compare_value;
            else if (top_hit)
                compare_active <= compare_value;
        end
    end

    // Waveform level and pin.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wave_level <= 1'b0;
            wave_out <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end
        else
        begin
            wave_level <= next_level;
            wave_out <= next_level;
            pin_out <= (output_action != twp_act_off)
                ? next_level : port_data;
            pin_oe <= pin_dir;
        end
    end

    // Flags: a hardware set wins over a clear in the same cycle.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            match_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else
        begin
            if (match)
                match_flag <= 1'b1;
            else if (match_ack || (wr_en && addr_lo == twp_flag_addr
                && pwdata[twp_match_bit]))
                match_flag <= 1'b0;
            if (timer_tick && ((mode == twp_phase)
                ? (count_value == twp_bottom)
                : (count_value == twp_max)))
                overflow_flag <= 1'b1;
            else if (overflow_ack || (wr_en && addr_lo == twp_flag_addr
                && pwdata[twp_ovf_bit]))
                overflow_flag <= 1'b0;
        end
    end

    always_comb
    begin
        unique case (addr_lo)
            twp_ctrl_addr: rd_byte = timer_mode_control;
            twp_count_addr: rd_byte = count_value;
            twp_cmp_addr: rd_byte = compare_value;
            twp_flag_addr: rd_byte = {6'h00, match_flag, overflow_flag};
            default: rd_byte = twp_byte_rst;
        endcase
    end

    // APB answers one cycle into the access phase.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable)
                prdata <= {24'h000000, mapped ? rd_byte : twp_byte_rst};
        end
    end

    // Fast PWM wrap: counter goes MAX to BOTTOM on a tick.
    fast_wrap_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_fast && timer_tick
        && count_value == twp_max && !wr_en) |=> count_value == twp_bottom)
        else $error("fast mode did not wrap");

    phase_turn_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_phase && timer_tick
        && count_value == twp_max && !wr_en && $past(mode) == twp_phase)
        |=> count_value == twp_max - twp_one)
        else $error("phase mode did not turn at max");

    no_tick_hold_a: assert property (@(posedge ref_clk)
        disable iff (srst) (!timer_tick && !wr_en) |=> $stable(count_value))
        else $error("counter moved without tick");

    match_clear_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_match_clr && match && !wr_en)
        |=> count_value == twp_bottom)
        else $error("clear-on-match did not clear");

    force_read_a: assert property (@(posedge ref_clk)
        disable iff (srst) timer_mode_control[twp_force_bit] == 1'b0)
        else $error("force bit stored");

    force_noflag_a: assert property (@(posedge ref_clk)
        disable iff (srst) (force_hit && !match && !match_flag)
        |=> !match_flag)
        else $error("force set match flag");

    flag_set_a: assert property (@(posedge ref_clk)
        disable iff (srst) match |=> match_flag)
        else $error("match flag not set");

    ovf_phase_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_phase && timer_tick
        && count_value == twp_bottom) |=> overflow_flag)
        else $error("overflow flag missing at bottom");

    pwm_buffer_a: assert property (@(posedge ref_clk)
        disable iff (srst) (pwm_mode && !top_hit && $past(pwm_mode))
        |=> $stable(compare_active))
        else $error("compare changed away from top");

    pin_route_a: assert property (@(posedge ref_clk)
        disable iff (srst) (output_action != twp_act_off)
        |=> pin_out == wave_out)
        else $error("pin not driven by waveform");

    ovf_max_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode != twp_phase && timer_tick
        && count_value == twp_max) |=> overflow_flag)
        else $error("overflow flag missing at max");

    fast_top_set_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_fast && top_hit && !wr_en
        && output_action == twp_act_clr) |=> wave_out)
        else $error("fast mode did not set at top");

    fast_match_clr_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_fast && match && !top_hit && !wr_en
        && output_action == twp_act_clr) |=> !wave_out)
        else $error("fast mode did not clear on match");

    phase_up_clr_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_phase && match && up_now && !wr_en
        && output_action == twp_act_clr) |=> !wave_out)
        else $error("phase mode did not clear counting up");

    phase_down_set_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_phase && match && !up_now && !wr_en
        && output_action == twp_act_clr) |=> wave_out)
        else $error("phase mode did not set counting down");

    toggle_match_a: assert property (@(posedge ref_clk)
        disable iff (srst) (!pwm_mode && match && !wr_en
        && output_action == twp_act_tog) |=> wave_out != $past(wave_out))
        else $error("waveform did not toggle on match");

    phase_bottom_a: assert property (@(posedge ref_clk)
        disable iff (srst) (mode == twp_phase && timer_tick && !wr_en
        && count_value == twp_bottom) |=> count_value == twp_one)
        else $error("phase mode did not turn at bottom");

    pin_port_a: assert property (@(posedge ref_clk)
        disable iff (srst) (output_action == twp_act_off)
        |=> pin_out == $past(port_data))
        else $error("pin not driven by port data");

    pin_dir_a: assert property (@(posedge ref_clk)
        disable iff (srst) 1'b1 |=> pin_oe == $past(pin_dir))
        else $error("driver enable does not follow direction");

    reset_zero_a: assert property (@(posedge ref_clk)
        srst |=> timer_mode_control == twp_byte_rst
        && count_value == twp_byte_rst && compare_value == twp_byte_rst
        && !wave_out)
        else $error("reset did not clear the timer");
endmodule : twp_timer

/* File: twp_timer_tb.sv */
// Self-checking testbench for the 8-bit timer waveform block.
module twp_timer_tb;
    import twp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic timer_tick = 1'b0;
    logic match_ack = 1'b0;
    logic overflow_ack = 1'b0;
    logic pin_dir = 1'b0;
    logic port_data = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pin_out, pin_oe, pin_level;
    logic wave_out, match_flag, overflow_flag;
    int err_count = 0;
    int compares = 0;
    logic [31:0] lfsr = 32'hddd6e287;
    logic [1:0] m_mode = 2'h0;
    logic [1:0] m_act = 2'h0;
    logic [7:0] m_buf = 8'h00;
    logic [7:0] m_cmp = 8'h00;
    logic [7:0] m_cnt = 8'h00;
    logic m_up = 1'b1;
    logic m_blk = 1'b0;
    logic m_wave = 1'b0;
    logic m_mf = 1'b0;
    logic m_of = 1'b0;
    logic [31:0] rd;
    logic er;

    always #10 ref_clk = ~ref_clk;

    twp_timer dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .match_ack(match_ack),
        .overflow_ack(overflow_ack), .pin_dir(pin_dir),
        .port_data(port_data), .pin_out(pin_out), .pin_oe(pin_oe),
        .wave_out(wave_out), .match_flag(match_flag),
        .overflow_flag(overflow_flag));
    twp_load_model load (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(pin_level));

    function logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task check(input logic [7:0] seen, input logic [7:0] exp, string what);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s %h not %h", $time, what, seen,
                exp);
        end
    endtask : check

    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // One timer tick of the reference model; set wins over any clear.
    task model_tick;
        logic hit, up, top;
        hit = m_cnt == m_cmp && !m_blk;
        top = m_cnt == twp_max;
        up = m_cnt == twp_bottom || (!top && m_up);
        if (hit)
            m_mf = 1'b1;
        if (m_mode == twp_wsel_phase ? m_cnt == twp_bottom : top)
            m_of = 1'b1;
        if (!m_mode[0] && hit && m_act != twp_act_off)
            m_wave = m_act == twp_act_tog ? ~m_wave : m_act[0];
        else if (m_mode == twp_wsel_fast && m_act[1] && (top || hit))
            m_wave = top ? ~m_act[0] : m_act[0];
        else if (m_mode == twp_wsel_phase && m_act[1] && hit)
            m_wave = up ? m_act[0] : ~m_act[0];
        if (m_mode == twp_wsel_phase)
            m_cnt = up ? m_cnt + 8'h01 : m_cnt - 8'h01;
        else if (m_mode == twp_wsel_match_clr && hit)
            m_cnt = twp_bottom;
        else
            m_cnt = m_cnt + 8'h01;
        if (m_mode[0] && top)
            m_cmp = m_buf;
        m_up = up;
        m_blk = 1'b0;
    endtask : model_tick

    task model_write(input logic [3:0] a, input logic [7:0] d);
        case (a)
            twp_ctrl_addr:
            begin
                m_mode = {d[6], d[3]};
                m_act = d[5:4];
                if (d[7] && !d[3] && m_act != twp_act_off)
                    m_wave = m_act == twp_act_tog ? ~m_wave : m_act[0];
            end
            twp_count_addr:
            begin
                m_cnt = d;
                m_blk = 1'b1;
            end
            twp_cmp_addr:
            begin
                m_buf = d;
                if (!m_mode[0])
                    m_cmp = d;
            end
            default:
            begin
                m_mf = m_mf & ~d[1];
                m_of = m_of & ~d[0];
            end
        endcase
    endtask : model_write

    task apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 8)
        begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 8)
        begin
            err_count++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && er !== 1'b1)
            model_write(a[3:0], d);
    endtask : apb

    task step(input logic rnd);
        @(posedge ref_clk);
        if (match_ack)
            m_mf = 1'b0;
        if (overflow_ack)
            m_of = 1'b0;
        if (timer_tick)
            model_tick();
        lfsr = next_rand(lfsr);
        timer_tick <= rnd && lfsr[1:0] != 2'h0;
        match_ack <= rnd && lfsr[7:4] == 4'h0;
        overflow_ack <= rnd && lfsr[11:8] == 4'h0;
        @(negedge ref_clk);
        check(8'(wave_out), 8'(m_wave),
            "wave");
        check(8'(match_flag), 8'(m_mf), "match flag");
        check(8'(overflow_flag), 8'(m_of), "overflow");
        check(8'(pin_out), 8'(m_act != 2'h0 ? m_wave : port_data),
            "pin");
        check(8'(pin_oe), 8'(pin_dir), "pin enable");
        if (pin_dir)
            check(8'(pin_level), 8'(pin_out), "load level");
    endtask : step

    initial
    begin
        logic [1:0] md, ac;
        logic [7:0] cv, ctl;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        step(1'b0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 32'(i * 4), 8'h00);
            check(rd[7:0], twp_byte_rst, "reset value");
        end
        // Unmapped and misaligned places answer with an error and read 0.
        apb(1'b1, 32'h10, 8'hff);
        check(8'(er), 8'h01, "error on write");
        apb(1'b0, 32'h2, 8'h00);
        check(8'(er), 8'h01, "error on read");
        check(rd[7:0], 8'h00, "error read data");
        for (int k = 0; k < 48; k++)
        begin
            md = 2'(k / 12);
            ac = 2'(k / 3);
            lfsr = next_rand(lfsr);
            cv = k % 3 == 0 ? twp_bottom : k % 3 == 1 ? twp_max : lfsr[7:0];
            pin_dir <= lfsr[8];
            port_data <= lfsr[9];
            ctl = {~md[0], md[1], ac, md[0], 3'b000};
            apb(1'b1, 32'(twp_ctrl_addr), 8'h00);
            apb(1'b1, 32'(twp_cmp_addr), cv);
            apb(1'b1, 32'(twp_count_addr), md[0] ? 8'h00 : lfsr[23:16]);
            apb(1'b1, 32'(twp_flag_addr), 8'h03);
            apb(1'b1, 32'(twp_ctrl_addr), ctl);
            step(1'b0);
            apb(1'b0, 32'(twp_ctrl_addr), 8'h00);
            check(rd[7:0], ctl & 8'h78, "control");
            apb(1'b0, 32'(twp_count_addr), 8'h00);
            check(rd[7:0], m_cnt, "count after force");
            for (int s = 0; s < 800; s++)
            begin
                step(1'b1);
                if (s % 100 == 99)
                begin
                    step(1'b0);
                    apb(1'b0, 32'(twp_count_addr), 8'h00);
                    check(rd[7:0], m_cnt,
                        "count");
                end
                if (s == 399)
                begin
                    apb(1'b1, 32'(twp_cmp_addr), lfsr[15:8]);
                    apb(1'b0, 32'(twp_cmp_addr), 8'h00);
                    check(rd[7:0], m_buf, "compare");
                end
            end
            $display("config %0d done", k);
        end
        report_and_stop();
    end
endmodule : twp_timer_tb

/* File: twp_wave_action.sv */
// Next waveform level from mode, output action and the current events.
module twp_wave_action
    import twp_pkg::*;
(
    // Mode and action.
    input wire twp_mode_type mode,
    input wire logic [1:0] output_action,
    input wire logic [7:0] compare_active,
    // Events of this cycle.
    input wire logic match,
    input wire logic top_hit,
    input wire logic up_now,
    input wire logic force_hit,
    // Level.
    input wire logic level,
    output logic next_level
);
    always_comb
    begin
        next_level = level;
        unique case (mode)
            twp_normal, twp_match_clr:
            begin
                if (match || force_hit)
                begin
                    unique case (output_action)
                        twp_act_tog: next_level = ~level;
                        twp_act_clr: next_level = 1'b0;
                        twp_act_set: next_level = 1'b1;
                        twp_act_off: next_level = level;
                    endcase
                end
            end
            twp_fast:
            begin
                if (output_action[1])
                begin
                    // A match on TOP is ignored so the TOP action rules.
                    if (top_hit)
                        next_level = ~output_action[0];
                    else if (match && compare_active != twp_max)
                        next_level = output_action[0];
                end
            end
            twp_phase:
            begin
                if (output_action[1] && match)
                    next_level = up_now ? output_action[0]
                        : ~output_action[0];
            end
        endcase
    end
endmodule : twp_wave_action
